// File: include/rtc_pkg.sv
package rtc_pkg;

  // Relay operation modes
  typedef enum logic [2:0] {
    RTC_MODE_INACTIVE = 3'h0,
    RTC_MODE_ON       = 3'h1,
    RTC_MODE_OFF      = 3'h3,
    RTC_MODE_IN       = 3'h2,
    RTC_MODE_OUT      = 3'h6,
    RTC_MODE_BUS      = 3'h7
  } rtc_mode_e;

  // Fault reaction choices
  typedef enum logic [1:0] {
    RTC_FR_KEEP  = 2'h0,
    RTC_FR_CLOSE = 2'h1,
    RTC_FR_OPEN  = 2'h3
  } rtc_fault_e;

  // Qualification state
  typedef enum logic [1:0] {
    RTC_Q_IDLE = 2'h0,
    RTC_Q_ON   = 2'h1,
    RTC_Q_OFF  = 2'h3
  } rtc_qual_e;

  // Per-relay configuration
  typedef struct packed {
    rtc_mode_e          mode;
    rtc_fault_e         fault_reaction;
    logic signed [15:0] first_threshold;
    logic signed [15:0] second_threshold;
    logic [9:0]         hysteresis_width;
    logic [9:0]         activation_delay;
    logic [9:0]         deactivation_delay;
    logic               unit_minutes;
    logic               use_peak;
    logic               buzzer_enable;
  } rtc_relay_cfg_s;

  // Input range configuration
  typedef struct packed {
    logic signed [15:0] nominal_min;
    logic signed [15:0] nominal_max;
    logic               zero_based;
    logic [9:0]         low_range_extension;
    logic [7:0]         high_range_extension;
    logic               user_char;
    logic [4:0]         char_points;
  } rtc_range_cfg_s;

  // Warning outputs
  typedef struct packed {
    logic under_range_warning;
    logic over_range_warning;
    logic display_overflow_warning;
    logic char_error_warning;
  } rtc_warn_s;

  localparam int unsigned     RTC_NRELAY      = 4;
  localparam int unsigned     RTC_CLK_HZ      = 40000000;
  localparam int unsigned     RTC_TENTH_MS    = 100;
  localparam int unsigned     RTC_TENTH_CYC   =
    RTC_CLK_HZ / 1000 * RTC_TENTH_MS;
  localparam logic [11:0]     RTC_MIN_TENTHS  = 12'h258;
  localparam logic [6:0]      RTC_SEC_TENTHS  = 7'h0a;
  localparam logic [9:0]      RTC_DELAY_MAX   = 10'h3e7;
  localparam logic [9:0]      RTC_HYSTERESIS_WIDTH_MAX    = 10'h3e7;
  localparam logic signed [15:0] RTC_DISP_MIN = -16'sd999;
  localparam logic signed [15:0] RTC_DISP_MAX = 16'sd9999;
  localparam logic [6:0]      RTC_GAP_MAX     = 7'h63;
  localparam logic [4:0]      RTC_MIN_POINTS  = 5'h02;
  localparam logic [1:0]      RTC_QUAL_RST    = 2'h0;

endpackage : rtc_pkg

// File: verilog/rtc_relay_threshold_controller.sv
`timescale 1ns/1ps
module rtc_relay_threshold_controller (
  input  wire logic                   i_mclk,        // 40 MHz clock
  input  wire logic                   i_rst_n,       // Sync reset, low
  input  wire logic                   i_meas_valid,  // New result pulse
  input  wire logic signed [15:0]     i_live_value,  // Display value live
  input  wire logic signed [15:0]     i_peak_value,  // Held peak value
  input  wire logic signed [15:0]     i_raw_input,   // Input, range units
  input  wire rtc_pkg::rtc_relay_cfg_s i_cfg [4],    // Relay settings
  input  wire rtc_pkg::rtc_range_cfg_s i_range,      // Range settings
  input  wire logic [6:0]             i_frame_gap_timeout, // Seconds
  input  wire logic                   i_frame_rx,    // Frame received
  input  wire logic [3:0]             i_bus_cmd,     // Bus relay states
  input  wire logic                   i_bus_cmd_we,  // Bus command write
  input  wire logic                   i_buzz_crit_en,// Buzzer on fault
  input  wire logic [3:0]             i_button,      // Front buttons, pins
  output logic [3:0]                  o_relay,       // Relay closed
  output logic [3:0]                  o_led,         // Relay LEDs
  output logic                        o_buzzer,      // Buzzer drive
  output logic                        o_critical,    // Any critical
  output rtc_pkg::rtc_warn_s          o_warn         // Warnings
);
  import rtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Timebase and button synchroniser
  logic [31:0] tick_cnt_r;
  logic        tenth_r;
  logic [3:0]  btn_m_r;
  logic [3:0]  btn_s_r;
  logic [6:0]  sec_div_r;
  logic        sec_r;

  // 0.1 s enable pulse
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tick_cnt_r <= '0;
      tenth_r    <= 1'b0;
    end else if (tick_cnt_r == RTC_TENTH_CYC - 1) begin
      tick_cnt_r <= '0;
      tenth_r    <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tenth_r    <= 1'b0;
    end
  end

  // One second enable pulse
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sec_div_r <= '0;
      sec_r     <= 1'b0;
    end else begin
      sec_r <= 1'b0;
      if (tenth_r) begin
        if (sec_div_r == RTC_SEC_TENTHS - 7'h1) begin
          sec_div_r <= '0;
          sec_r     <= 1'b1;
        end else begin
          sec_div_r <= sec_div_r + 7'h1;
        end
      end
    end
  end

  // Two-stage button synchroniser
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      btn_m_r <= '0;
      btn_s_r <= '0;
    end else begin
      btn_m_r <= i_button;
      btn_s_r <= btn_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Range supervision and warnings
  logic signed [31:0] lo_border;
  logic signed [31:0] hi_border;
  logic               under_rng;
  logic               over_rng;
  logic               range_crit;

  // Borders in tenths of a percent of nominal
  always_comb begin
    if (i_range.zero_based) begin
      lo_border = 32'sd0;
    end else begin
      lo_border = (32'(i_range.nominal_min) * 32'sd1000 -
                   32'(i_range.nominal_min) *
                   $signed({22'h0, i_range.low_range_extension})) /
                  32'sd1000;
    end
    hi_border = (32'(i_range.nominal_max) * 32'sd1000 +
                 32'(i_range.nominal_max) *
                 $signed({24'h0, i_range.high_range_extension})) /
                32'sd1000;
    under_rng  = 32'(i_raw_input) < lo_border;
    over_rng   = 32'(i_raw_input) > hi_border;
    range_crit = under_rng | over_rng;
  end

  // Warnings refresh on each result
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_warn <= '0;
    end else if (i_meas_valid) begin
      o_warn.under_range_warning <= under_rng;
      o_warn.over_range_warning  <= over_rng;
      o_warn.display_overflow_warning <= !range_crit &&
        (i_live_value < RTC_DISP_MIN ||
         i_live_value > RTC_DISP_MAX);
      o_warn.char_error_warning <= i_range.user_char &&
        (i_range.char_points < RTC_MIN_POINTS);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame gap supervision
  logic [6:0] gap_cnt_r;
  logic       gap_crit_r;

  // Seconds since last frame
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      gap_cnt_r  <= '0;
      gap_crit_r <= 1'b0;
    end else if (i_frame_rx || i_frame_gap_timeout == 7'h0) begin
      gap_cnt_r  <= '0;
      gap_crit_r <= 1'b0;
    end else if (sec_r) begin
      if (gap_cnt_r != RTC_GAP_MAX) begin
        gap_cnt_r <= gap_cnt_r + 7'h1;
      end
      if (gap_cnt_r + 7'h1 > i_frame_gap_timeout) begin
        gap_crit_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus command latch, volatile
  logic [3:0] bus_state_r;

  // Cleared at reset so commanded states do not survive power loss
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      bus_state_r <= '0;
    end else if (i_bus_cmd_we) begin
      bus_state_r <= i_bus_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-relay evaluation
  logic [3:0]  relay_r;
  logic [3:0]  crit_vec;
  rtc_qual_e   qual_r    [4];
  logic [21:0] qual_cnt_r[4];

  for (genvar g = 0; g < RTC_NRELAY; g++) begin : g_relay
    logic signed [17:0] val;
    logic signed [17:0] lo_t;
    logic signed [17:0] hi_t;
    logic signed [17:0] hy;
    logic               want_on;
    logic               want_off;
    logic               crit;
    logic [21:0]        target;

    // Switch-on and switch-off borders
    always_comb begin
      val = i_cfg[g].use_peak ? 18'(i_peak_value)
                              : 18'(i_live_value);
      hy  = $signed({8'h0, i_cfg[g].hysteresis_width});
      if (i_cfg[g].first_threshold <= i_cfg[g].second_threshold) begin
        lo_t = 18'(i_cfg[g].first_threshold);
        hi_t = 18'(i_cfg[g].second_threshold);
      end else begin
        lo_t = 18'(i_cfg[g].second_threshold);
        hi_t = 18'(i_cfg[g].first_threshold);
      end
      want_on  = 1'b0;
      want_off = 1'b0;
      unique case (i_cfg[g].mode)
        RTC_MODE_ON: begin
          want_on  = val > 18'(i_cfg[g].first_threshold) + hy;
          want_off = val < 18'(i_cfg[g].first_threshold) - hy;
        end
        RTC_MODE_OFF: begin
          want_off = val > 18'(i_cfg[g].first_threshold) + hy;
          want_on  = val < 18'(i_cfg[g].first_threshold) - hy;
        end
        RTC_MODE_IN: begin
          want_on  = val > lo_t + hy && val < hi_t - hy;
          want_off = val < lo_t - hy || val > hi_t + hy;
        end
        RTC_MODE_OUT: begin
          want_on  = val > hi_t + hy || val < lo_t - hy;
          want_off = val > lo_t + hy && val < hi_t - hy;
        end
        RTC_MODE_INACTIVE: want_off = 1'b1;
        RTC_MODE_BUS: begin
          want_on  = 1'b0;
          want_off = 1'b0;
        end
        default: want_off = 1'b1;
      endcase
      if (i_cfg[g].mode == RTC_MODE_BUS) begin
        crit = gap_crit_r;
      end else if (i_cfg[g].mode == RTC_MODE_INACTIVE) begin
        crit = range_crit;
      end else begin
        crit = range_crit;
      end
      target = want_on ? {12'h0, i_cfg[g].activation_delay}
                       : {12'h0, i_cfg[g].deactivation_delay};
      if (i_cfg[g].unit_minutes) begin
        target = target * 22'(RTC_MIN_TENTHS); // Minutes in tenths
      end
    end

    assign crit_vec[g] = crit;

    // Delay qualification and relay state
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        relay_r[g]    <= 1'b0;
        qual_r[g]     <= RTC_Q_IDLE;
        qual_cnt_r[g] <= 22'(RTC_QUAL_RST);
      end else if (crit && i_cfg[g].fault_reaction != RTC_FR_KEEP) begin
        relay_r[g] <= (i_cfg[g].fault_reaction == RTC_FR_CLOSE);
        qual_r[g]  <= RTC_Q_IDLE;
      end else if (crit) begin
        qual_r[g] <= RTC_Q_IDLE;
      end else if (i_cfg[g].mode == RTC_MODE_BUS) begin
        relay_r[g] <= bus_state_r[g];
        qual_r[g]  <= RTC_Q_IDLE;
      end else if (i_cfg[g].mode == RTC_MODE_INACTIVE) begin
        relay_r[g] <= 1'b0;
        qual_r[g]  <= RTC_Q_IDLE;
      end else if (i_meas_valid) begin
        if (want_on && !relay_r[g]) begin
          if (qual_r[g] != RTC_Q_ON) begin
            qual_r[g]     <= RTC_Q_ON;
            qual_cnt_r[g] <= '0;
            if (target == 22'h0) begin
              relay_r[g] <= 1'b1;
            end
          end else if (22'(qual_cnt_r[g]) >= target) begin
            relay_r[g] <= 1'b1;
            qual_r[g]  <= RTC_Q_IDLE;
          end
        end else if (want_off && relay_r[g]) begin
          if (qual_r[g] != RTC_Q_OFF) begin
            qual_r[g]     <= RTC_Q_OFF;
            qual_cnt_r[g] <= '0;
            if (target == 22'h0) begin
              relay_r[g] <= 1'b0;
            end
          end else if (22'(qual_cnt_r[g]) >= target) begin
            relay_r[g] <= 1'b0;
            qual_r[g]  <= RTC_Q_IDLE;
          end
        end else begin
          qual_r[g] <= RTC_Q_IDLE;
        end
      end else if (tenth_r && qual_r[g] != RTC_Q_IDLE &&
                   qual_cnt_r[g] != 22'h3fffff) begin
        qual_cnt_r[g] <= qual_cnt_r[g] + 22'h1; // Wide enough for minutes
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and buzzer
  logic [3:0] relay_d_r;
  logic       crit_d_r;
  logic       any_crit;
  logic [3:0] buzz_en;

  always_comb begin
    any_crit = |crit_vec;
    for (int k = 0; k < RTC_NRELAY; k++) begin
      buzz_en[k] = i_cfg[k].buzzer_enable;
    end
  end

  // Relay and LED drive
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_relay    <= '0;
      o_led      <= '0;
      o_critical <= 1'b0;
      relay_d_r  <= '0;
      crit_d_r   <= 1'b0;
    end else begin
      o_relay    <= relay_r;
      o_led      <= relay_r;
      o_critical <= any_crit;
      relay_d_r  <= relay_r;
      crit_d_r   <= any_crit;
    end
  end

  // Buzzer set on new events, silenced by any button
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_buzzer <= 1'b0;
    end else if ((any_crit && !crit_d_r && i_buzz_crit_en) ||
                 |(relay_r & ~relay_d_r & buzz_en)) begin
      o_buzzer <= 1'b1;
    end else if (|btn_s_r) begin
      o_buzzer <= 1'b0;
    end
  end

endmodule : rtc_relay_threshold_controller

// File: bench/rtc_props.sv
`timescale 1ns/1ps
module rtc_props
  import rtc_pkg::*;
(
  input wire logic                    i_mclk,       // Clock
  input wire logic                    i_rst_n,      // Sync reset, low
  input wire logic                    i_meas_valid, // New result
  input wire logic signed [15:0]      i_live_value, // Display value
  input wire logic signed [15:0]      i_raw_input,  // Input value
  input wire rtc_pkg::rtc_relay_cfg_s i_cfg [4],    // Relay settings
  input wire rtc_pkg::rtc_range_cfg_s i_range,      // Range settings
  input wire logic [6:0]              i_frame_gap_timeout, // Seconds
  input wire logic [3:0]              i_bus_cmd,    // Bus states
  input wire logic                    i_bus_cmd_we, // Bus write
  input wire logic [3:0]              i_button,     // Buttons
  input wire logic [3:0]              o_relay,      // Relays
  input wire logic [3:0]              o_led,        // LEDs
  input wire logic                    o_buzzer,     // Buzzer
  input wire logic                    o_critical,   // Critical
  input wire rtc_pkg::rtc_warn_s      o_warn        // Warnings
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Range borders are exact only when no extension applies
  logic       no_ext, under_raw, over_raw, in_rng;
  logic [3:0] relay_q_r;
  logic       crit_q_r;
  logic [2:0] quiet_cnt_r;
  assign no_ext = i_range.low_range_extension == 10'h000 &&
                  i_range.high_range_extension == 8'h00 && !i_range.zero_based;
  assign under_raw = no_ext && i_raw_input < i_range.nominal_min;
  assign over_raw = no_ext && i_raw_input > i_range.nominal_max;
  assign in_rng = no_ext && !under_raw && !over_raw;
  // Cycles of a held button with no relay or critical edge in sight
  always_ff @(posedge i_mclk) begin
    relay_q_r <= o_relay;
    crit_q_r <= o_critical;
    if (!i_rst_n || i_button == 4'h0 || o_relay != relay_q_r ||
        o_critical != crit_q_r) begin
      quiet_cnt_r <= 3'h0;
    end else if (quiet_cnt_r != 3'h7) begin
      quiet_cnt_r <= quiet_cnt_r + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Bus write followed by a quiet spell
  sequence s_bus_wr;
    i_bus_cmd_we && i_cfg[0].mode == RTC_MODE_BUS &&
      i_frame_gap_timeout == 7'h00;
  endsequence
  sequence s_bus_quiet;
    !i_bus_cmd_we [*3];
  endsequence
  a_led_follow: assert property (o_led == o_relay)
    else $error("led differs from relay");
  a_inactive_open: assert property (i_meas_valid && in_rng &&
    i_cfg[0].mode == RTC_MODE_INACTIVE |-> ##2 !o_relay[0])
    else $error("inactive relay closed");
  a_warn_under: assert property (i_meas_valid && under_raw
    |=> o_warn.under_range_warning) else $error("no under warning");
  a_warn_overflow: assert property (i_meas_valid && in_rng &&
    (i_live_value > RTC_DISP_MAX || i_live_value < RTC_DISP_MIN)
    |=> o_warn.display_overflow_warning) else $error("no overflow");
  a_char_error: assert property (i_meas_valid && i_range.user_char &&
    i_range.char_points < RTC_MIN_POINTS |=> o_warn.char_error_warning)
    else $error("no characteristic warning");
  a_crit_range: assert property (i_meas_valid && (under_raw || over_raw) &&
    i_cfg[0].mode != RTC_MODE_BUS |-> ##[1:2] o_critical)
    else $error("range violation not critical");
  a_fault_close: assert property (i_meas_valid && over_raw &&
    i_cfg[0].fault_reaction == RTC_FR_CLOSE &&
    i_cfg[0].mode != RTC_MODE_BUS |-> ##2 o_relay[0])
    else $error("fault did not force close");
  a_bus_follow: assert property (s_bus_wr ##1 s_bus_quiet |->
    o_relay[0] == $past(i_bus_cmd[0], 3)) else $error("bus state lost");
  a_buzz_relay: assert property ($rose(o_relay[0]) &&
    i_cfg[0].buzzer_enable && i_button == 4'h0 |-> ##[0:2] o_buzzer)
    else $error("no buzzer on relay close");
  a_buzz_silence: assert property (quiet_cnt_r == 3'h6 |-> !o_buzzer)
    else $error("buzzer not silenced");
  a_reset_clear: assert property (@(posedge i_mclk) disable iff (1'b0)
    !i_rst_n |=> o_relay == 4'h0 && !o_buzzer && !o_critical)
    else $error("outputs not cleared by reset");
endmodule : rtc_props

bind rtc_relay_threshold_controller rtc_props rtc_props_i (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_meas_valid(i_meas_valid),
  .i_live_value(i_live_value), .i_raw_input(i_raw_input), .i_cfg(i_cfg),
  .i_range(i_range), .i_frame_gap_timeout(i_frame_gap_timeout),
  .i_bus_cmd(i_bus_cmd), .i_bus_cmd_we(i_bus_cmd_we), .i_button(i_button),
  .o_relay(o_relay), .o_led(o_led), .o_buzzer(o_buzzer),
  .o_critical(o_critical), .o_warn(o_warn));

// File: bench/rtc_front_model.sv
`timescale 1ns/1ps
module rtc_front_model (
  input  wire logic               i_mclk,     // Bench clock
  input  wire logic signed [15:0] i_live_set, // Wanted display value
  input  wire logic signed [15:0] i_raw_set,  // Wanted input value
  output logic                    o_valid,    // New result pulse
  output logic signed [15:0]      o_live,     // Live value
  output logic signed [15:0]      o_peak,     // Held peak
  output logic signed [15:0]      o_raw       // Input value
);
  logic [2:0] div_r = 3'h0;
  // Quiet start before the first result
  initial begin
    o_valid = 1'b0;
    o_live = 16'sh0000;
    o_peak = 16'sh0000;
    o_raw = 16'sh0000;
  end
  // One result every eight cycles, launched off the falling edge
  always @(negedge i_mclk) begin
    div_r <= div_r + 3'h1;
    o_valid <= (div_r == 3'h7);
    o_live <= i_live_set;
    o_raw <= i_raw_set;
    if (i_live_set > o_peak) begin
      o_peak <= i_live_set;
    end
  end
endmodule : rtc_front_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rtc_pkg::*;
  logic               mclk, rst_n, meas_valid, bus_we, crit_en, buzzer;
  logic               critical, frame_rx;
  logic [6:0]         gap_to;
  logic signed [15:0] live, peak, raw, live_set, raw_set;
  logic [3:0]         bus_cmd, button, relay, led;
  rtc_relay_cfg_s     cfg [4];
  rtc_range_cfg_s     rng;
  rtc_warn_s          warn;
  int                 fail_count, cmp_count, cyc;
  rtc_mode_e          t_mode [17] = '{RTC_MODE_ON, RTC_MODE_ON, RTC_MODE_ON,
    RTC_MODE_ON, RTC_MODE_OFF, RTC_MODE_OFF, RTC_MODE_OFF, RTC_MODE_IN,
    RTC_MODE_IN, RTC_MODE_IN, RTC_MODE_IN, RTC_MODE_OUT, RTC_MODE_OUT,
    RTC_MODE_OUT, RTC_MODE_OUT, RTC_MODE_OUT, RTC_MODE_INACTIVE};
  int                 t_val [17] = '{110, 111, 90, 89, 89, 110, 111, 150, 195,
    250, 150, 150, 211, 205, 150, 89, 150};
  logic               t_on [17] = '{0, 1, 1, 0, 1, 1, 0, 1, 1, 0, 1, 0, 1, 1,
    0, 1, 0};
  ////////////////////////////////////////////////////////////////////////
  // Clock and cycle limit
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  rtc_front_model rtc_front_model_i (.i_mclk(mclk), .i_live_set(live_set),
    .i_raw_set(raw_set), .o_valid(meas_valid), .o_live(live), .o_peak(peak),
    .o_raw(raw));
  rtc_relay_threshold_controller rtc_relay_threshold_controller_i (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_meas_valid(meas_valid),
    .i_live_value(live), .i_peak_value(peak), .i_raw_input(raw), .i_cfg(cfg),
    .i_range(rng), .i_frame_gap_timeout(gap_to), .i_frame_rx(frame_rx),
    .i_bus_cmd(bus_cmd), .i_bus_cmd_we(bus_we), .i_buzz_crit_en(crit_en),
    .i_button(button), .o_relay(relay), .o_led(led), .o_buzzer(buzzer),
    .o_critical(critical), .o_warn(warn));
  ////////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic chk(input logic [3:0] got, input logic [3:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic set_cfg(input rtc_mode_e m, input rtc_fault_e f,
                         input logic be);
    rtc_relay_cfg_s c;
    logic           dual;
    dual = (m == RTC_MODE_IN || m == RTC_MODE_OUT);
    c = '0;
    c.mode = m;
    c.fault_reaction = f;
    c.first_threshold = dual ? 16'sd200 : 16'sd100;
    c.second_threshold = dual ? 16'sd100 : 16'sd200;
    c.hysteresis_width = 10'h00a;
    c.buzzer_enable = be;
    for (int k = 0; k < 4; k++) begin
      cfg[k] = c;
    end
  endtask : set_cfg
  task automatic meas(input int l, input int r);
    live_set <= 16'(l);
    raw_set <= 16'(r);
    repeat (24) @(negedge mclk);
  endtask : meas
  task automatic bus_wr(input logic [3:0] v);
    bus_cmd = v;
    bus_we = 1'b1;
    @(negedge mclk);
    bus_we = 1'b0;
    repeat (5) @(negedge mclk);
  endtask : bus_wr
  task automatic press();
    button = 4'h2;
    repeat (8) @(negedge mclk);
    chk({3'h0, buzzer}, 4'h0, "silence");
    button = 4'h0;
    repeat (4) @(negedge mclk);
  endtask : press
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst_n = 1'b0;
    cfg = '{default: '0};
    rng = '0;
    rng.nominal_min = -16'sd50;
    rng.nominal_max = 16'sd50;
    {bus_cmd, bus_we, crit_en, button, frame_rx, gap_to} = '0;
    live_set = 16'sh0000;
    raw_set = 16'sh0000;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    for (int s = 0; s < 17; s++) begin
      set_cfg(t_mode[s], RTC_FR_KEEP, 1'b0);
      meas(t_val[s], 0);
      chk(relay, {4{t_on[s]}}, "mode");
      chk(led, {4{t_on[s]}}, "led");
    end
    set_cfg(RTC_MODE_ON, RTC_FR_KEEP, 1'b0);
    foreach (cfg[k]) begin
      cfg[k].use_peak = 1'b1;
    end
    meas(50, 0);
    chk(relay, 4'hf, "peak");
    $display("test modes done");
    crit_en = 1'b1;
    set_cfg(RTC_MODE_INACTIVE, RTC_FR_CLOSE, 1'b0);
    meas(150, 60);
    chk(warn, 4'h4, "over");
    chk({3'h0, critical}, 4'h1, "critical");
    chk(relay, 4'hf, "forced");
    chk({3'h0, buzzer}, 4'h1, "crit buzz");
    press();
    meas(150, -60);
    chk(warn, 4'h8, "under");
    meas(150, 0);
    chk(relay, 4'h0, "resume");
    set_cfg(RTC_MODE_ON, RTC_FR_OPEN, 1'b0);
    meas(150, 0);
    meas(150, 60);
    chk(relay, 4'h0, "open");
    meas(150, 0);
    set_cfg(RTC_MODE_ON, RTC_FR_KEEP, 1'b0);
    meas(50, 60);
    chk(relay, 4'hf, "keep");
    meas(50, 0);
    chk(relay, 4'h0, "resume");
    $display("test fault done");
    crit_en = 1'b0;
    press();
    set_cfg(RTC_MODE_ON, RTC_FR_KEEP, 1'b1);
    meas(150, 0);
    chk({3'h0, buzzer}, 4'h1, "relay buzz");
    press();
    $display("test buzzer done");
    rng.zero_based = 1'b1;
    rng.low_range_extension = 10'h3e7;
    meas(0, -1);
    chk(warn, 4'h8, "zero based");
    rng.zero_based = 1'b0;
    rng.nominal_min = 16'sd40;
    meas(0, 1);
    chk(warn, 4'h0, "extended");
    rng.low_range_extension = 10'h000;
    rng.nominal_min = -16'sd50;
    meas(10000, 0);
    chk(warn, 4'h2, "overflow hi");
    meas(-1000, 0);
    chk(warn, 4'h2, "overflow lo");
    rng.user_char = 1'b1;
    rng.char_points = 5'h01;
    meas(0, 0);
    chk(warn, 4'h1, "char");
    rng.char_points = 5'h02;
    meas(0, 0);
    chk(warn, 4'h0, "char ok");
    $display("test warnings done");
    set_cfg(RTC_MODE_BUS, RTC_FR_KEEP, 1'b0);
    bus_wr(4'h5);
    chk(relay, 4'h5, "bus");
    chk({3'h0, critical}, 4'h0, "no gap fault");
    meas(9000, 0);
    chk(relay, 4'h5, "bus hold");
    bus_wr(4'ha);
    chk(led, 4'ha, "bus led");
    rst_n = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    meas(0, 0);
    chk(relay, 4'h0, "bus lost");
    $display("test bus done");
    summarize();
  end
endmodule : tb_top
